// ===== hw/dbgx_core.sv
// dbgx_core: debug control register, event priority and debug entry
// assumes: events are core-clock pulses; i_ext_break and test port are async
`timescale 1ns/1ps

module dbgx_core
  import dbgx_pkg::*;
(
  // core clock and reset
  input  wire logic        i_clock,
  input  wire logic        i_rst_b,
  // test port
  input  wire logic        i_tck,
  input  wire logic        i_trst_b,
  input  wire logic        i_scan_wr,
  input  wire logic [31:0] i_scan_wdata,
  input  wire logic        i_scan_rd,
  output logic      [31:0] o_scan_rdata,
  output logic             o_scan_rvalid,
  // software register access
  input  wire logic        i_cp_wr,
  input  wire logic        i_cp_rd,
  input  wire logic        i_cp_priv,
  input  wire logic [31:0] i_cp_wdata,
  output logic      [31:0] o_cp_rdata,
  output logic             o_cp_denied,
  // core events and state
  input  wire dbgx_ev_s    i_ev,
  input  wire logic        i_ext_break,
  input  wire logic [31:0] i_current_status_word,
  input  wire logic [31:0] i_pc_next,
  input  wire logic [31:0] i_pc_fault,
  input  wire logic        i_vec_reloc,
  // entry and status outputs
  output dbgx_entry_s      o_entry,
  output logic             o_fault_update,
  output logic             o_fsr_bit9,
  output logic             o_reset_hold,
  output logic             o_sds,
  output logic             o_instruction_mmu_bypass,
  output logic             o_pid_bypass,
  output logic             o_trace_run,
  output logic      [31:0] o_debug_control_status
);
  typedef struct packed {
    logic        ge;
    logic        sa;
    logic [2:0]  moe;
    logic        tmode;
    logic        ten;
    logic        special_debug_state;
    logic        pend_ext;
    logic        pend_tf;
    logic [1:0]  rst_cnt;
    logic        rst_hold;
    logic        req_seen;
    logic        ack_tgl;
    logic [31:0] rd_word;
    logic [31:0] cp_rdata;
    logic        cp_denied;
    logic        fault_upd;
    logic        fsr9;
    logic        trace_run;
    dbgx_entry_s entry;
    logic [31:0] debug_control_status;
  } dbgx_core_s;

  dbgx_core_s  st_q;
  dbgx_core_s  st_d;
  dbgx_cfg_s   cfg_l;
  dbgx_cfg_s   cfg;
  logic        req_l;
  logic        req_s;
  logic        ext_s;
  logic        dbg_on;
  logic        in_abort;
  logic        rst_trap;
  logic        vt_hit;
  logic        ext_raw;
  logic        tf_raw;
  logic        ext_now;
  logic        tf_now;
  logic        sw_ok;
  logic [11:2] act;
  logic [3:0]  level;
  logic        dbg_take;
  logic [31:0] debug_control_status_now;

  function automatic logic [3:0] pick(input logic [11:2] a);
    logic [3:0] r;
    r = 4'h0;
    for (int i = 11; i >= 2; i--)
      if (a[i])
        r = 4'(i);
    return r;
  endfunction

  dbgx_link u_link (
    .i_tck         (i_tck),
    .i_trst_b      (i_trst_b),
    .i_scan_wr     (i_scan_wr),
    .i_scan_wdata  (i_scan_wdata),
    .i_scan_rd     (i_scan_rd),
    .o_scan_rdata  (o_scan_rdata),
    .o_scan_rvalid (o_scan_rvalid),
    .i_rd_word     (st_q.rd_word),
    .i_ack_tgl     (st_q.ack_tgl),
    .o_cfg         (cfg_l),
    .o_req_tgl     (req_l)
  );

  dbgx_sync #(.W(10)) u_sync (
    .i_clock (i_clock),
    .i_rst_b (i_rst_b),
    .i_async ({cfg_l, req_l, i_ext_break}),
    .o_sync  ({cfg, req_s, ext_s})
  );

  // event qualification
  assign dbg_on   = st_q.ge & ~st_q.special_debug_state;
  assign in_abort = (i_current_status_word[4:0] == MODE_ABORT);
  assign rst_trap = (st_q.rst_cnt == RST_CHECK) & cfg.halt & cfg.trap[TRAP_TR];
  assign vt_hit   = dbg_on & cfg.halt & |(i_ev.vec_hit & cfg.trap[6:1]);
  assign ext_raw  = st_q.ge & ext_s;
  assign tf_raw   = st_q.ge & st_q.ten & st_q.tmode & i_ev.trace_full;
  assign ext_now  = ~st_q.special_debug_state & ~in_abort & (ext_raw | st_q.pend_ext);
  assign tf_now   = ~st_q.special_debug_state & ~in_abort & (tf_raw | st_q.pend_tf);
  assign sw_ok    = i_cp_priv & (~cfg.halt | st_q.special_debug_state);

  // priority arbitration
  always_comb
  begin
    act     = '0;
    act[2]  = rst_trap | vt_hit;
    act[3]  = i_ev.dabt_precise & ~st_q.special_debug_state;
    act[4]  = i_ev.dbkpt & dbg_on;
    act[5]  = i_ev.dabt_imprecise & ~st_q.special_debug_state;
    act[6]  = ext_now | tf_now;
    act[7]  = i_ev.fiq & ~st_q.special_debug_state;
    act[8]  = i_ev.irq & ~st_q.special_debug_state;
    act[9]  = i_ev.ibkpt & dbg_on;
    act[10] = i_ev.pabt & ~st_q.special_debug_state;
    act[11] = i_ev.undef | i_ev.swi | (i_ev.bkpt_insn & dbg_on);
  end

  assign level    = pick(act);
  assign dbg_take = (level == PRI_VTRAP) | (level == PRI_DBKPT) | (level == PRI_EXT)
                  | (level == PRI_IBKPT)
                  | ((level == PRI_SWBK) & ~i_ev.undef & ~i_ev.swi);

  always_comb
  begin
    debug_control_status_now                  = '0;
    debug_control_status_now[DEBUG_CONTROL_STATUS_GE_BIT]     = st_q.ge;
    debug_control_status_now[DEBUG_CONTROL_STATUS_H_BIT]      = cfg.halt;
    debug_control_status_now[DEBUG_CONTROL_STATUS_TF_BIT]     = cfg.trap[6];
    debug_control_status_now[DEBUG_CONTROL_STATUS_TI_BIT]     = cfg.trap[5];
    debug_control_status_now[DEBUG_CONTROL_STATUS_TD_BIT]     = cfg.trap[4];
    debug_control_status_now[DEBUG_CONTROL_STATUS_TA_BIT]     = cfg.trap[3];
    debug_control_status_now[DEBUG_CONTROL_STATUS_TS_BIT]     = cfg.trap[2];
    debug_control_status_now[DEBUG_CONTROL_STATUS_TU_BIT]     = cfg.trap[1];
    debug_control_status_now[DEBUG_CONTROL_STATUS_TR_BIT]     = cfg.trap[TRAP_TR];
    debug_control_status_now[DEBUG_CONTROL_STATUS_SA_BIT]     = st_q.sa;
    debug_control_status_now[DEBUG_CONTROL_STATUS_MOE_LSB+:3] = st_q.moe;
    debug_control_status_now[DEBUG_CONTROL_STATUS_TM_BIT]     = st_q.tmode;
    debug_control_status_now[DEBUG_CONTROL_STATUS_TE_BIT]     = st_q.ten;
  end

  always_comb
  begin
    st_d           = st_q;
    st_d.entry     = '0;
    st_d.cp_denied = 1'b0;
    st_d.cp_rdata  = '0;
    st_d.fault_upd = 1'b0;
    st_d.fsr9      = 1'b0;
    st_d.debug_control_status      = debug_control_status_now;
    if (st_q.rst_cnt != 2'h0)
      st_d.rst_cnt = st_q.rst_cnt - 2'h1;
    st_d.rst_hold = (st_d.rst_cnt != 2'h0);
    // software access
    if ((i_cp_wr | i_cp_rd) & ~sw_ok)
      st_d.cp_denied = 1'b1;
    if (i_cp_rd & sw_ok)
      st_d.cp_rdata = debug_control_status_now;
    if (i_cp_wr & sw_ok)
    begin
      st_d.ge    = i_cp_wdata[DEBUG_CONTROL_STATUS_GE_BIT];
      st_d.sa    = i_cp_wdata[DEBUG_CONTROL_STATUS_SA_BIT];
      st_d.tmode = i_cp_wdata[DEBUG_CONTROL_STATUS_TM_BIT];
      st_d.ten   = i_cp_wdata[DEBUG_CONTROL_STATUS_TE_BIT];
    end
    // aborts inside special debug state
    if (st_q.special_debug_state & (i_ev.dabt_precise | i_ev.dabt_imprecise))
    begin
      st_d.sa        = 1'b1;
      st_d.fault_upd = 1'b1;
    end
    // breaks held while in abort mode
    st_d.pend_ext = (st_q.pend_ext & ~dbg_take) | (ext_raw & in_abort);
    st_d.pend_tf  = (st_q.pend_tf & ~dbg_take) | (tf_raw & in_abort);
    if (i_ev.current_status_word_restore)
      st_d.special_debug_state = 1'b0;
    // entry
    st_d.entry.take  = |act;
    st_d.entry.level = level;
    if (dbg_take)
    begin
      st_d.entry.debug = 1'b1;
      st_d.entry.saved = i_current_status_word;
      st_d.ten         = 1'b0;
      case (level)
        PRI_VTRAP: st_d.moe = MOE_VTRAP;
        PRI_DBKPT: st_d.moe = MOE_DBKPT;
        PRI_EXT:   st_d.moe = ext_now ? MOE_EXT : MOE_TFULL;
        PRI_IBKPT: st_d.moe = MOE_IBKPT;
        default:   st_d.moe = MOE_BKPT;
      endcase
      if ((level == PRI_DBKPT) | (level == PRI_EXT))
        st_d.entry.link = i_pc_next + LINK_OFS;
      else
        st_d.entry.link = i_pc_fault + LINK_OFS;
      if (cfg.halt)
      begin
        st_d.special_debug_state          = 1'b1;
        st_d.entry.to_dbg = 1'b1;
        st_d.entry.vector = i_vec_reloc ? VEC_HALT_HI : VEC_HALT;
        st_d.entry.current_status_word   = {i_current_status_word[31:8], 3'h6, MODE_DEBUG};
      end
      else
      begin
        st_d.fsr9         = 1'b1;
        st_d.entry.vector = ((level == PRI_DBKPT) | (level == PRI_EXT)) ? VEC_DABT
                                                                        : VEC_PABT;
        st_d.entry.current_status_word   = {i_current_status_word[31:8], 1'b1, i_current_status_word[6], 1'b0, MODE_ABORT};
      end
    end
    st_d.trace_run = st_d.ten & st_d.ge;
    // scan read handshake
    if (req_s != st_q.req_seen)
    begin
      st_d.req_seen = req_s;
      st_d.rd_word  = debug_control_status_now;
      st_d.ack_tgl  = ~st_q.ack_tgl;
    end
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
    begin
      st_q         <= '0;
      st_q.ge      <= GE_RST;
      st_q.rst_cnt <= RST_WAIT;
      st_q.rst_hold <= 1'b1;
    end
    else
      st_q <= st_d;
  end

  assign o_entry        = st_q.entry;
  assign o_cp_rdata     = st_q.cp_rdata;
  assign o_cp_denied    = st_q.cp_denied;
  assign o_fault_update = st_q.fault_upd;
  assign o_fsr_bit9     = st_q.fsr9;
  assign o_reset_hold   = st_q.rst_hold;
  assign o_sds          = st_q.special_debug_state;
  assign o_instruction_mmu_bypass  = st_q.special_debug_state;
  assign o_pid_bypass   = st_q.special_debug_state;
  assign o_trace_run    = st_q.trace_run;
  assign o_debug_control_status         = st_q.debug_control_status;

  chk_ge_bkpt_nop:
  assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (!st_q.ge && i_ev.bkpt_insn && !i_ev.undef && !i_ev.swi)
      |=> !(o_entry.take && o_entry.debug))
  else $error("breakpoint taken with debug disabled");

  chk_halt_vector:
  assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (o_entry.take && o_entry.debug && o_entry.to_dbg)
      |-> o_entry.vector == ($past(i_vec_reloc) ? VEC_HALT_HI : VEC_HALT))
  else $error("halt debug vector wrong");

  chk_halt_entry_status:
  assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (o_entry.take && o_entry.debug && o_entry.to_dbg)
      |-> (o_entry.current_status_word[7:0] == {3'h6, MODE_DEBUG}) && o_sds
          && (o_entry.saved == $past(i_current_status_word)) && !st_q.ten)
  else $error("halt entry state wrong");

  chk_mon_entry_status:
  assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (o_entry.take && o_entry.debug && !o_entry.to_dbg)
      |-> (o_entry.current_status_word[4:0] == MODE_ABORT) && o_entry.current_status_word[7] && !o_entry.current_status_word[5]
          && o_fsr_bit9 && !o_sds
          && ((o_entry.vector == VEC_PABT) || (o_entry.vector == VEC_DABT)))
  else $error("monitor entry state wrong");

  chk_sds_abort_sticky:
  assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (o_sds && i_ev.dabt_precise)
      |=> st_q.sa && o_fault_update && !(o_entry.take && (o_entry.level == PRI_DABT_P)))
  else $error("abort in special state mishandled");

  chk_sds_irq_ignored:
  assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (o_sds && i_ev.irq) |=> !(o_entry.take && (o_entry.level == PRI_IRQ)))
  else $error("interrupt taken in special state");

  chk_sds_exit:
  assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (o_sds && i_ev.current_status_word_restore) |=> !o_sds && !o_instruction_mmu_bypass && !o_pid_bypass)
  else $error("special state not left on restore");

  chk_moe_dbkpt:
  assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (o_entry.take && o_entry.debug && (o_entry.level == PRI_DBKPT))
      |-> (st_q.moe == MOE_DBKPT) && (o_entry.link == $past(i_pc_next) + LINK_OFS))
  else $error("data breakpoint cause or link wrong");

  chk_abort_pend:
  assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (ext_raw && in_abort) |=> st_q.pend_ext)
  else $error("break not pended in abort mode");

  chk_sw_denied:
  assert property (@(posedge i_clock) disable iff (!i_rst_b)
    (i_cp_wr && cfg.halt && !st_q.special_debug_state) |=> o_cp_denied && $stable(st_q.ge))
  else $error("software write allowed in halt mode");
endmodule

// ===== hw/dbgx_pkg.sv
// dbgx_pkg: constants, field layout and carriers of the debug control block
// assumes: shared by the core-clock logic and the test-port clock logic
package dbgx_pkg;

  // debug_control_status bit positions
  localparam int DEBUG_CONTROL_STATUS_GE_BIT  = 31;
  localparam int DEBUG_CONTROL_STATUS_H_BIT   = 30;
  localparam int DEBUG_CONTROL_STATUS_TF_BIT  = 23;
  localparam int DEBUG_CONTROL_STATUS_TI_BIT  = 22;
  localparam int DEBUG_CONTROL_STATUS_TD_BIT  = 20;
  localparam int DEBUG_CONTROL_STATUS_TA_BIT  = 19;
  localparam int DEBUG_CONTROL_STATUS_TS_BIT  = 18;
  localparam int DEBUG_CONTROL_STATUS_TU_BIT  = 17;
  localparam int DEBUG_CONTROL_STATUS_TR_BIT  = 16;
  localparam int DEBUG_CONTROL_STATUS_SA_BIT  = 5;
  localparam int DEBUG_CONTROL_STATUS_MOE_LSB = 2;
  localparam int DEBUG_CONTROL_STATUS_TM_BIT  = 1;
  localparam int DEBUG_CONTROL_STATUS_TE_BIT  = 0;

  // trap vector index inside the scan-owned trap field
  localparam int TRAP_TR = 0;

  // method-of-entry codes
  typedef enum logic [2:0] {
    MOE_RESET = 3'h0,
    MOE_IBKPT = 3'h1,
    MOE_DBKPT = 3'h2,
    MOE_BKPT  = 3'h3,
    MOE_EXT   = 3'h4,
    MOE_VTRAP = 3'h5,
    MOE_TFULL = 3'h6
  } dbgx_moe_e;

  // event priority levels, 1 highest
  localparam logic [3:0] PRI_RESET  = 4'h1;
  localparam logic [3:0] PRI_VTRAP  = 4'h2;
  localparam logic [3:0] PRI_DABT_P = 4'h3;
  localparam logic [3:0] PRI_DBKPT  = 4'h4;
  localparam logic [3:0] PRI_DABT_I = 4'h5;
  localparam logic [3:0] PRI_EXT    = 4'h6;
  localparam logic [3:0] PRI_FIQ    = 4'h7;
  localparam logic [3:0] PRI_IRQ    = 4'h8;
  localparam logic [3:0] PRI_IBKPT  = 4'h9;
  localparam logic [3:0] PRI_PABT   = 4'ha;
  localparam logic [3:0] PRI_SWBK   = 4'hb;

  // processor modes, vectors, link offset
  localparam logic [4:0]  MODE_DEBUG  = 5'h15;
  localparam logic [4:0]  MODE_ABORT  = 5'h17;
  localparam logic [31:0] VEC_HALT    = 32'h0;
  localparam logic [31:0] VEC_HALT_HI = 32'hffff0000;
  localparam logic [31:0] VEC_PABT    = 32'hc;
  localparam logic [31:0] VEC_DABT    = 32'h10;
  localparam logic [31:0] LINK_OFS    = 32'h4;

  // reset values and reset-trap settle count
  localparam logic       GE_RST    = 1'b0;
  localparam logic [1:0] RST_WAIT  = 2'h3;
  localparam logic [1:0] RST_CHECK = 2'h1;

  // scan-owned bits: halt select and trap bits tf,ti,td,ta,ts,tu,tr
  typedef struct packed {
    logic       halt;
    logic [6:0] trap;
  } dbgx_cfg_s;

  // core events, vec_hit order fiq,irq,dabt,pabt,swi,undef
  typedef struct packed {
    logic       dabt_precise;
    logic       dbkpt;
    logic       dabt_imprecise;
    logic       trace_full;
    logic       fiq;
    logic       irq;
    logic       ibkpt;
    logic       pabt;
    logic       undef;
    logic       swi;
    logic       bkpt_insn;
    logic [5:0] vec_hit;
    logic       current_status_word_restore;
    logic       current_status_word_write;
  } dbgx_ev_s;

  // exception entry request to the core
  typedef struct packed {
    logic        take;
    logic        debug;
    logic        to_dbg;
    logic [3:0]  level;
    logic [31:0] vector;
    logic [31:0] link;
    logic [31:0] current_status_word;
    logic [31:0] saved;
  } dbgx_entry_s;

endpackage

// ===== hw/dbgx_sync.sv
// dbgx_sync: two-flop level synchroniser, W bits wide
// assumes: each bit is an independent level or a toggle
`timescale 1ns/1ps
module dbgx_sync #(
  parameter int W = 1
) (
  // clock and reset
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  // data
  input  wire logic [W-1:0] i_async,
  output logic      [W-1:0] o_sync
);
  typedef struct packed {
    logic [W-1:0] meta;
    logic [W-1:0] stable;
  } dbgx_sync_s;

  dbgx_sync_s st_q;
  dbgx_sync_s st_d;

  always_comb
  begin
    st_d        = st_q;
    st_d.meta   = i_async;
    st_d.stable = st_q.meta;
  end

  always_ff @(posedge i_clock or negedge i_rst_b)
  begin
    if (!i_rst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign o_sync = st_q.stable;
endmodule

// ===== hw/dbgx_link.sv
// dbgx_link: test-port side, owns halt and trap bits, serves scan reads
// assumes: i_rd_word held stable by the core between ack toggles
`timescale 1ns/1ps
module dbgx_link
  import dbgx_pkg::*;
(
  // test-port clock and reset
  input  wire logic      i_tck,
  input  wire logic      i_trst_b,
  // scan access
  input  wire logic        i_scan_wr,
  input  wire logic [31:0] i_scan_wdata,
  input  wire logic        i_scan_rd,
  output logic      [31:0] o_scan_rdata,
  output logic             o_scan_rvalid,
  // core-domain crossing
  input  wire logic [31:0] i_rd_word,
  input  wire logic        i_ack_tgl,
  output dbgx_cfg_s        o_cfg,
  output logic             o_req_tgl
);
  typedef struct packed {
    dbgx_cfg_s   cfg;
    logic        req_tgl;
    logic        ack_seen;
    logic        rvalid;
    logic [31:0] rdata;
  } dbgx_link_s;

  dbgx_link_s st_q;
  dbgx_link_s st_d;
  logic       ack_s;

  dbgx_sync #(.W(1)) u_ack_sync (
    .i_clock (i_tck),
    .i_rst_b (i_trst_b),
    .i_async (i_ack_tgl),
    .o_sync  (ack_s)
  );

  always_comb
  begin
    st_d        = st_q;
    st_d.rvalid = 1'b0;
    if (i_scan_wr)
    begin
      st_d.cfg.halt = i_scan_wdata[DEBUG_CONTROL_STATUS_H_BIT];
      st_d.cfg.trap = {i_scan_wdata[DEBUG_CONTROL_STATUS_TF_BIT], i_scan_wdata[DEBUG_CONTROL_STATUS_TI_BIT],
                       i_scan_wdata[DEBUG_CONTROL_STATUS_TD_BIT], i_scan_wdata[DEBUG_CONTROL_STATUS_TA_BIT],
                       i_scan_wdata[DEBUG_CONTROL_STATUS_TS_BIT], i_scan_wdata[DEBUG_CONTROL_STATUS_TU_BIT],
                       i_scan_wdata[DEBUG_CONTROL_STATUS_TR_BIT]};
    end
    if (i_scan_rd)
      st_d.req_tgl = ~st_q.req_tgl;
    if (ack_s != st_q.ack_seen)
    begin
      st_d.ack_seen = ack_s;
      st_d.rdata    = i_rd_word;
      st_d.rvalid   = 1'b1;
    end
  end

  // test-port reset clears halt select and traps
  always_ff @(posedge i_tck or negedge i_trst_b)
  begin
    if (!i_trst_b)
      st_q <= '0;
    else
      st_q <= st_d;
  end

  assign o_cfg         = st_q.cfg;
  assign o_req_tgl     = st_q.req_tgl;
  assign o_scan_rdata  = st_q.rdata;
  assign o_scan_rvalid = st_q.rvalid;
endmodule

// ===== verif/dbgx_host.sv
// dbgx_host: debugger model on the serial test port
// assumes: test clock runs only while an access is in progress
`timescale 1ns/1ps
module dbgx_host (
  // test port to the device
  output logic             o_tck,
  output logic             o_trst_b,
  output logic             o_scan_wr,
  output logic      [31:0] o_scan_wdata,
  output logic             o_scan_rd,
  input  wire logic [31:0] i_scan_rdata,
  input  wire logic        i_scan_rvalid
);
  initial
  begin
    o_tck = 1'b0;
    o_trst_b = 1'b0;
    o_scan_wr = 1'b0;
    o_scan_wdata = 32'h0;
    o_scan_rd = 1'b0;
    #100 o_trst_b = 1'b1;
  end
  task automatic tick();
    #80 o_tck = 1'b1;
    #80 o_tck = 1'b0;
  endtask
  // test-port reset drops halt and trap bits
  task automatic trst();
    o_trst_b = 1'b0;
    tick();
    o_trst_b = 1'b1;
  endtask
  task automatic scan_write(input logic [31:0] d);
    o_scan_wr = 1'b1;
    o_scan_wdata = d;
    tick();
    o_scan_wr = 1'b0;
    o_scan_wdata = ~d;
    repeat (3) tick();
  endtask
  task automatic scan_read(output logic [31:0] d, output logic ok);
    o_scan_rd = 1'b1;
    tick();
    o_scan_rd = 1'b0;
    ok = 1'b0;
    d = 32'h0;
    for (int n = 0; n < 40 && !ok; n++)
    begin
      #80 ok = (i_scan_rvalid === 1'b1);
      d = i_scan_rdata;
      o_tck = 1'b1;
      #80 o_tck = 1'b0;
    end
  endtask
endmodule

// ===== verif/debug_control_exception_entry_tb_top.sv
// tb: software, event and scan traffic against expected values
// assumes: dbgx_core and dbgx_host compiled first
`timescale 1ns/1ps
module debug_control_exception_entry_tb_top;
  import dbgx_pkg::*;
  logic        i_clock, i_rst_b, cp_wr, cp_rd, cp_priv, ext_break, vec_reloc;
  logic        tck, trst_b, scan_wr, scan_rd, scan_rvalid, denied, fupd, fsr9;
  logic        rhold, special_debug_state, instruction_mmu_byp, pid_byp, trace_run, den, seen, ok;
  logic [31:0] cp_wdata, cp_rdata, current_status_word, pc_next, pc_fault, debug_control_status;
  logic [31:0] scan_wdata, scan_rdata, rd, d;
  dbgx_ev_s    ev;
  dbgx_entry_s entry, ent;
  int          miscompares, n_compared;
  // event masks in dbgx_ev_s bit order
  localparam logic [18:0] ev_dabt = 19'h40000, ev_dbk = 19'h20000, ev_tf = 19'h08000;
  localparam logic [18:0] ev_fiq = 19'h04000, ev_irq = 19'h02000, ev_ibk = 19'h01000;
  localparam logic [18:0] ev_pabt = 19'h00800, ev_bki = 19'h00100, ev_vfiq = 19'h00080;
  localparam logic [18:0] ev_rst = 19'h00002, ev_wr = 19'h00001;
  logic [18:0] mon_ev [4] = '{ev_dbk, ev_tf, ev_ibk, ev_bki};
  dbgx_moe_e   mon_moe [4] = '{MOE_DBKPT, MOE_TFULL, MOE_IBKPT, MOE_BKPT};

  initial
  begin
    i_clock = 1'b0;
    forever #12.5 i_clock = ~i_clock;
  end

  dbgx_core dbgx_core_inst (
    .i_clock(i_clock), .i_rst_b(i_rst_b), .i_tck(tck), .i_trst_b(trst_b),
    .i_scan_wr(scan_wr), .i_scan_wdata(scan_wdata), .i_scan_rd(scan_rd),
    .o_scan_rdata(scan_rdata), .o_scan_rvalid(scan_rvalid),
    .i_cp_wr(cp_wr), .i_cp_rd(cp_rd), .i_cp_priv(cp_priv), .i_cp_wdata(cp_wdata),
    .o_cp_rdata(cp_rdata), .o_cp_denied(denied), .i_ev(ev), .i_ext_break(ext_break),
    .i_current_status_word(current_status_word), .i_pc_next(pc_next), .i_pc_fault(pc_fault), .i_vec_reloc(vec_reloc),
    .o_entry(entry), .o_fault_update(fupd), .o_fsr_bit9(fsr9), .o_reset_hold(rhold),
    .o_sds(special_debug_state), .o_instruction_mmu_bypass(instruction_mmu_byp), .o_pid_bypass(pid_byp),
    .o_trace_run(trace_run), .o_debug_control_status(debug_control_status)
  );
  dbgx_host dbgx_host_inst (
    .o_tck(tck), .o_trst_b(trst_b), .o_scan_wr(scan_wr), .o_scan_wdata(scan_wdata),
    .o_scan_rd(scan_rd), .i_scan_rdata(scan_rdata), .i_scan_rvalid(scan_rvalid)
  );

  task automatic check(input logic [63:0] s, input logic [63:0] x);
    n_compared++;
    if (s !== x)
    begin
      miscompares++;
      $display("CHECK FAILED %0t: got %h want %h", $time, s, x);
    end
  endtask
  task automatic results();
    if (miscompares == 0 && n_compared > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic fire(input logic [18:0] v);
    @(posedge i_clock) ev <= v;
    @(posedge i_clock) ev <= '0;
    #1 ent = entry;
  endtask
  task automatic cp(input logic w, input logic p, input logic [31:0] v);
    @(posedge i_clock) {cp_wr, cp_rd, cp_priv, cp_wdata} <= {w, !w, p, v};
    @(posedge i_clock) {cp_wr, cp_rd} <= 2'b00;
    #1 rd = cp_rdata;
    den = denied;
  endtask
  task automatic wait_take(input int n, input logic x);
    seen = 1'b0;
    for (int i = 0; i < n && !seen; i++)
    begin
      @(posedge i_clock) #1 seen = (entry.take === 1'b1);
      ent = entry;
    end
    check(seen, x);
    if (x && !seen)
      results();
  endtask

  initial
  begin
    {i_rst_b, cp_wr, cp_rd, cp_priv, ext_break, vec_reloc} = 6'b000100;
    cp_wdata = 32'h0;
    ev = '0;
    current_status_word = 32'h53;
    pc_next = 32'h2000;
    pc_fault = 32'h1ffc;
    miscompares = 0;
    n_compared = 0;
    repeat (20) @(posedge i_clock);
    i_rst_b <= 1'b1;
    repeat (3) @(posedge i_clock);
    #1 check(debug_control_status, 32'h0);
    fire(ev_dbk | ev_ibk | ev_bki);
    check(ent.take, 0);
    cp(1'b1, 1'b1, 32'hffffffff);
    cp(1'b0, 1'b1, 32'h0);
    check(rd, 32'h80000023);
    cp(1'b1, 1'b1, 32'h80000001);
    fire(ev_tf);
    check(ent.take, 0);
    check(trace_run, 1);
    cp(1'b0, 1'b0, 32'h0);
    check({den, rd}, 33'h100000000);
    // monitor mode entries, one per cause
    for (int i = 0; i < 4; i++)
    begin
      cp(1'b1, 1'b1, 32'h80000003);
      fire(mon_ev[i]);
      check(ent.vector, i < 2 ? VEC_DABT : VEC_PABT);
      check(ent.link, (i < 2 ? pc_next : pc_fault) + LINK_OFS);
      check({ent.to_dbg, ent.current_status_word[7:0]}, {2'b01, current_status_word[6], 1'b0, MODE_ABORT});
      check(ent.saved, current_status_word);
      check({ent.take, ent.debug, fsr9, trace_run}, 4'b1110);
      @(posedge i_clock) #1 check(debug_control_status[4:0], {mon_moe[i], 2'b10});
    end
    dbgx_host_inst.scan_write(32'h00800000);
    repeat (8) @(posedge i_clock);
    fire(ev_vfiq);
    check(ent.take, 0);
    // external break pends in abort mode
    @(posedge i_clock) {ext_break, current_status_word} <= {1'b1, 32'h57};
    wait_take(6, 1'b0);
    @(posedge i_clock) ext_break <= 1'b0;
    wait_take(6, 1'b0);
    @(posedge i_clock) current_status_word <= 32'h53;
    wait_take(4, 1'b1);
    check(ent.vector, VEC_DABT);
    wait_take(6, 1'b0);
    // halt mode with a fiq vector trap
    dbgx_host_inst.scan_write(32'h40800000);
    repeat (8) @(posedge i_clock);
    dbgx_host_inst.scan_read(d, ok);
    check(ok, 1);
    if (!ok)
      results();
    check(d, 32'hc0800012);
    cp(1'b0, 1'b1, 32'h0);
    check({den, rd}, 33'h100000000);
    cp(1'b1, 1'b1, 32'h0);
    check(den, 1);
    fire(ev_vfiq | ev_dbk | ev_ibk);
    check(ent.level, PRI_VTRAP);
    check(ent.vector, VEC_HALT);
    check(ent.link, pc_fault + LINK_OFS);
    check({ent.to_dbg, ent.current_status_word[7:0]}, 9'h1d5);
    check(ent.saved, current_status_word);
    @(posedge i_clock) #1 check(debug_control_status[4:2], MOE_VTRAP);
    check({special_debug_state, instruction_mmu_byp, pid_byp}, 3'b111);
    fire(ev_fiq | ev_irq | ev_pabt);
    check(ent.take, 0);
    fire(ev_dabt);
    check({ent.take, fupd}, 2'b01);
    @(posedge i_clock) #1 check(debug_control_status[5], 1);
    cp(1'b1, 1'b1, 32'h80000000);
    check(den, 0);
    cp(1'b0, 1'b1, 32'h0);
    check(rd, 32'hc0800014);
    fire(ev_wr);
    @(posedge i_clock) #1 check(special_debug_state, 1);
    fire(ev_rst);
    @(posedge i_clock) vec_reloc <= 1'b1;
    #1 check(special_debug_state, 0);
    fire(ev_dbk);
    check(ent.vector, VEC_HALT_HI);
    check(ent.link, pc_next + LINK_OFS);
    fire(ev_rst);
    @(posedge i_clock) vec_reloc <= 1'b0;
    // reset vector trap armed across a processor reset
    dbgx_host_inst.scan_write(32'h40010000);
    repeat (8) @(posedge i_clock);
    @(posedge i_clock) i_rst_b <= 1'b0;
    repeat (3) @(posedge i_clock);
    #1 check(rhold, 1);
    @(posedge i_clock) i_rst_b <= 1'b1;
    wait_take(6, 1'b1);
    check(ent.vector, VEC_HALT);
    check(rhold, 0);
    @(posedge i_clock) #1 check(debug_control_status[31:30], 2'b01);
    dbgx_host_inst.trst();
    repeat (6) @(posedge i_clock);
    #1 check(debug_control_status[30], 0);
    results();
  end
endmodule
